// file: sim/hprp_monitor.sv
// pin-level checker for the host read port, one instance beside the carrier
// assumes one clock shared by both ends and a synchronous active-high reset
`include "hprp_map.svh"
module hprp_monitor (
  // clocking
  input wire logic        clock,
  input wire logic        reset,
  // pins
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic [7:0]  addr,
  input wire logic [15:0] data_out,
  input wire logic        data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  logic       act;     // a read cycle is running
  logic       act_ff;  // act one edge ago
  logic [7:0] gap_ff;  // idle samples since the last cycle, saturating
  logic [7:0] cyc_ff;  // edges since the last cycle start, saturating
  logic [7:0] last_ff; // address of the previous cycle
  assign act = !chip_select_n && !read_strobe_n;
  // counters start saturated so the first cycle after reset owes no wait
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      act_ff  <= 1'b0;
      gap_ff  <= 8'hff;
      cyc_ff  <= 8'hff;
      last_ff <= 8'hff;
    end
    else
    begin
      act_ff  <= act;
      gap_ff  <= act ? 8'h00 : (gap_ff == 8'hff ? gap_ff : gap_ff + 8'h01);
      cyc_ff  <= (act && !act_ff) ? 8'h01 : (cyc_ff == 8'hff ? cyc_ff : cyc_ff + 8'h01);
      last_ff <= (act && !act_ff) ? addr : last_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_start;
    !act ##1 act;
  endsequence
  sequence s_stop;
    act ##1 !act;
  endsequence
  a_oe_start: assert property (act |=> data_oe)
    else $error("data bus not driven during cycle");
  a_oe_release: assert property (!act |=> !data_oe)
    else $error("data bus driven outside cycle");
  a_byte_test: assert property (act && addr == `HPRP_A_BYTE_TEST
    |=> data_out == `HPRP_BYTE_TEST_VAL)
    else $error("byte test word wrong");
  // a counter word is latched at cycle start, so it stands still while strobes stay low
  a_snap_hold: assert property (act && $past(act) && addr == `HPRP_A_FREE_RUN
    |=> $stable(data_out))
    else $error("counter word moved during its read cycle");
  a_addr_steady: assert property (act && $past(act) |-> $stable(addr))
    else $error("address moved inside a single cycle");
  a_low_time: assert property (s_start |-> act[*4])
    else $error("strobes low too short");
  a_high_gap: assert property (s_stop |-> !act[*2])
    else $error("strobes high too short");
  a_cycle_time: assert property (s_start |-> cyc_ff >= 8'(`HPRP_CYC_CYCLE))
    else $error("read cycle shorter than minimum");
  a_rx_info_wait: assert property (s_start ##0 (addr == `HPRP_A_RECEIVE_FIFO_INFORMATION
    && last_ff < `HPRP_A_TX_STS) |-> gap_ff >= 8'(`HPRP_CYC_CYCLE))
    else $error("receive info read too soon");
  a_tx_info_wait: assert property (s_start ##0 (addr == `HPRP_A_TRANSMIT_FIFO_INFORMATION
    && last_ff == `HPRP_A_TX_STS) |-> gap_ff >= 8'(`HPRP_CYC_CYCLE))
    else $error("transmit info read too soon");
  a_drop_wait: assert property (s_start ##0 (addr == `HPRP_A_RX_DROP
    && last_ff == `HPRP_A_RX_DROP) |-> gap_ff >= 8'(`HPRP_CYC_LONG))
    else $error("drop counter reread too soon");
  a_dpctl_wait: assert property (s_start ##0 ((addr == `HPRP_A_TX_STS
    || addr == `HPRP_A_RX_STS) && last_ff == `HPRP_A_RECEIVE_DATAPATH_CONTROL)
    |-> gap_ff >= 8'(`HPRP_CYC_LONG))
    else $error("status read too soon after datapath control");
endmodule : hprp_monitor

// file: sim/tb_top.sv
// bench joining host and device ends over the carrier, driven by the software port
// assumes hprp_map.svh on the include path and a 100 MHz clock
`include "hprp_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  logic        clock, reset, enable, rx_valid, rx_ready, frame_dropped, reg_write, reg_read;
  logic [15:0] rx_data, rx_status_word, tx_status_word, reg_wdata, reg_rdata, d;
  logic [3:0]  reg_addr;
  int          err_total, n_checks, n;
  hprp_if bus ();
  hprp_host hprp_host_inst (.clock(clock), .reset(reset), .enable(enable), .pins(bus),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  hprp_device #(.DEPTH(16)) hprp_device_inst (.clock(clock), .reset(reset), .enable(enable),
    .pins(bus), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_status_word(rx_status_word), .tx_status_word(tx_status_word),
    .frame_dropped(frame_dropped));
  hprp_monitor hprp_monitor_inst (.clock(clock), .reset(reset),
    .chip_select_n(bus.chip_select_n), .read_strobe_n(bus.read_strobe_n), .addr(bus.addr),
    .data_out(bus.data_out), .data_oe(bus.data_oe));
  ////////////////////////////////////////////////////////////////////////////
  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wreg
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rreg
  // one pin read through the host: command, poll until done and idle, fetch
  task automatic hread(input logic [7:0] a, output logic [15:0] v);
    logic [15:0] s;
    logic        seen;
    seen = 1'b0;
    wreg(`HPRP_R_CMD, {8'h00, a});
    for (int i = 0; i < 200 && !(seen && !s[1]); i++)
    begin
      rreg(`HPRP_R_STATUS, s);
      seen = seen | s[0];
    end
    if (!(seen && !s[1]))
    begin
      err_total++;
      $display("BAD %0t host read never finished", $time);
    end
    rreg(`HPRP_R_DATA, v);
  endtask : hread
  task automatic hchk(input logic [7:0] a, input logic [15:0] exp);
    hread(a, d);
    chk(d, exp);
  endtask : hchk
  task automatic conclude();
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs roughly a thousand cycles
  initial
  begin
    repeat (30000) @(posedge clock);
    err_total++;
    conclude();
  end
  // main sequence
  initial
  begin
    {reset, enable} = 2'b11;
    {rx_valid, frame_dropped, reg_write, reg_read} = 4'h0;
    {rx_data, reg_wdata, reg_addr} = '0;
    rx_status_word = 16'h5a21;
    tx_status_word = 16'h0c3f;
    {err_total, n_checks} = 0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    hchk(`HPRP_A_BYTE_TEST, `HPRP_BYTE_TEST_VAL);
    hchk(`HPRP_A_RX_STS, 16'h5a21);
    hchk(`HPRP_A_TX_STS, 16'h0c3f);
    hread(`HPRP_A_TRANSMIT_FIFO_INFORMATION, d);
    hchk(8'h7e, 16'h0000);
    hread(`HPRP_A_RECEIVE_DATAPATH_CONTROL, d);
    hchk(`HPRP_A_TX_STS, 16'h0c3f);
    hread(`HPRP_A_FREE_RUN, d);
    // two separate drop pulses, then a read that clears the counter
    repeat (2)
    begin
      @(posedge clock);
      frame_dropped <= 1'b1;
      @(posedge clock);
      frame_dropped <= 1'b0;
    end
    hchk(`HPRP_A_RX_DROP, 16'h0002);
    hchk(`HPRP_A_RX_DROP, 16'h0000);
    // frozen for a while: a drop pulse seen with enable low must not count
    @(posedge clock);
    enable        <= 1'b0;
    frame_dropped <= 1'b1;
    @(posedge clock);
    frame_dropped <= 1'b0;
    repeat (4) @(posedge clock);
    enable <= 1'b1;
    hchk(`HPRP_A_RX_DROP, 16'h0000);
    // fill the receive fifo until it refuses; ready is settled by the falling edge
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data  <= 16'ha000;
    n = 0;
    repeat (20)
    begin
      @(negedge clock);
      if (rx_ready)
      begin
        @(posedge clock);
        n++;
        rx_data <= 16'ha000 + 16'(n);
      end
    end
    chk({15'h0000, rx_ready}, 16'h0000);
    @(posedge clock);
    rx_valid <= 1'b0;
    chk(16'(n), 16'h0010);
    hchk(`HPRP_A_RECEIVE_FIFO_INFORMATION, 16'h0010);
    // drain in order, walking the data window addresses
    for (int i = 0; i < 16; i++)
      hchk(8'(2 * i), 16'ha000 + 16'(i));
    hchk(`HPRP_A_RECEIVE_FIFO_INFORMATION, 16'h0000);
    hchk(`HPRP_A_RX_DATA, 16'h0000);
    conclude();
  end
endmodule : tb_top

// file: verilog/hprp_device.sv
// device end of the host read port: register reads and receive fifo drain
// assumes pins synchronous to clock; receive words come in over a valid/ready stream
//
// Notes on behaviour
// - host waits after rx fifo reads before info
// - host waits after tx status before info
// - drop counter reads spaced by 330 ns
// - wait after datapath control before status reads
// - dummy byte test reads may count waits
// - counters latched at read cycle start
// - single reads reach registers and fifos
// - cycle runs while select and strobe low
// - host single cycle low, high, total times
// - bursts up to 16 words, slow address
// - high gap between bursts
// - burst data valid within 40 ns
`include "hprp_map.svh"
module hprp_device #(
  parameter int DEPTH = 16
) (
  // clocking
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        enable,
  // pins
  hprp_if.device           pins,
  // receive data stream in
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [15:0] rx_data,
  // status words and dropped-frame pulse
  input  wire logic [15:0] rx_status_word,
  input  wire logic [15:0] tx_status_word,
  input  wire logic        frame_dropped
);
  localparam int LW = $clog2(DEPTH) + 1;  // level width, holds a full fifo
  typedef struct packed {
    logic        active;     // read cycle in progress
    logic [7:0]  addr;       // last address seen
    logic [15:0] free_run;   // free running counter
    logic [15:0] drop;       // dropped frame counter
    logic [15:0] free_snap;  // counter snapshots
    logic [15:0] drop_snap;
    logic [15:0] dout;       // data on the pins
    logic        oe;
    logic [LW-1:0] lvl;      // receive fifo level shown in info
  } hprp_dst_t;
  hprp_dst_t   st_ff, nxt_st;
  logic        sel;
  logic        fifo_valid, fifo_pop;
  logic [15:0] fifo_data;
  assign sel = !pins.chip_select_n && !pins.read_strobe_n;
  assign pins.data_out = st_ff.dout;
  assign pins.data_oe  = st_ff.oe;
  ////////////////////////////////////////////////////////////////////////////
  // receive buffer; back-pressure reaches the stream source
  hprp_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_rxf (
    .clock     (clock),
    .reset     (reset),
    .enable    (enable),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  // one pop for each new data-port word: cycle start or address change in a burst
  assign fifo_pop = enable && sel && fifo_valid && pins.addr < 8'h20 &&
                    (!st_ff.active || pins.addr != st_ff.addr);
  ////////////////////////////////////////////////////////////////////////////
  // read decode, snapshot and drive
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.free_run = st_ff.free_run + 16'h0001;
    // level follows pushes and pops, kept for the information word
    nxt_st.lvl = st_ff.lvl + LW'(rx_valid && rx_ready) - LW'(fifo_pop);
    if (frame_dropped) nxt_st.drop = st_ff.drop + 16'h0001;
    nxt_st.active = sel;
    nxt_st.addr   = pins.addr;
    nxt_st.oe     = sel;
    if (sel && !st_ff.active)
    begin
      nxt_st.free_snap = st_ff.free_run;
      nxt_st.drop_snap = st_ff.drop;
      if (pins.addr == `HPRP_A_RX_DROP) nxt_st.drop = 16'h0000 + 16'(frame_dropped);
    end
    // data follows the address within one cycle, inside the 40 ns limit
    if (!sel) nxt_st.dout = 16'h0000;
    else if (pins.addr < `HPRP_A_RX_STS)
    begin
      // the popped word must stand for the whole strobe, not the next head word
      if (fifo_pop) nxt_st.dout = fifo_data;
      else if (!st_ff.active || pins.addr != st_ff.addr) nxt_st.dout = 16'h0000;
    end
    else
      case (pins.addr)
        `HPRP_A_RX_STS:      nxt_st.dout = rx_status_word;
        `HPRP_A_TX_STS:      nxt_st.dout = tx_status_word;
        `HPRP_A_BYTE_TEST:   nxt_st.dout = `HPRP_BYTE_TEST_VAL;
        `HPRP_A_RECEIVE_FIFO_INFORMATION: nxt_st.dout = 16'(st_ff.lvl);
        `HPRP_A_FREE_RUN:    nxt_st.dout = st_ff.active ? st_ff.free_snap : st_ff.free_run;
        `HPRP_A_RX_DROP:     nxt_st.dout = st_ff.active ? st_ff.drop_snap : st_ff.drop;
        default:             nxt_st.dout = 16'h0000;
      endcase
  end
  // state register
  always_ff @(posedge clock)
  begin
    if (reset) st_ff <= '0;
    else if (enable) st_ff <= nxt_st;
  end
endmodule : hprp_device

// file: verilog/hprp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock; clock enable freezes it
module hprp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clocking
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             enable,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } hprp_fst_t;
  hprp_fst_t        st_ff, nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];   // storage words
  logic             push, pop;
  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = mem_ff[st_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // pointer and count update
  always_comb
  begin
    nxt_st = st_ff;
    if (push) nxt_st.wp = st_ff.wp + 1'b1;
    if (pop)  nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  // registers; memory has no reset
  always_ff @(posedge clock)
  begin
    if (reset) st_ff <= '0;
    else if (enable) st_ff <= nxt_st;
    if (enable && push) mem_ff[st_ff.wp] <= in_data;
  end
endmodule : hprp_fifo

// file: verilog/hprp_host.sv
// host end: runs single read cycles on the pins under a small command port
// assumes software port per house convention, read data one cycle after strobe
`include "hprp_map.svh"
module hprp_host (
  // clocking
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        enable,
  // pins
  hprp_if.host             pins,
  // software port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata
);
  typedef struct packed {
    hprp_pkg::hprp_hstate_t st;
    hprp_pkg::hprp_kind_t   last;  // kind of previous read
    logic [7:0]  tgt;              // requested address
    logic [7:0]  cnt;              // phase counter
    logic [7:0]  since;            // cycles since last read ended
    logic [15:0] data;             // captured word
    logic        done;             // sticky done flag
    logic        cs_n, rd_n;
    logic [7:0]  a;
    logic [15:0] rdata;
  } hprp_hst_t;
  hprp_hst_t  st_ff, nxt_st;
  logic [7:0] need;
  assign pins.chip_select_n = st_ff.cs_n;
  assign pins.read_strobe_n = st_ff.rd_n;
  assign pins.addr          = st_ff.a;
  assign reg_rdata          = st_ff.rdata;
  // wait needed before reading target after the previous kind
  function automatic logic [7:0] wait_for(input hprp_pkg::hprp_kind_t k, input logic [7:0] t);
    wait_for = 8'(`HPRP_CYC_CSH);
    if (k == hprp_pkg::rk_rx_fifo && t == `HPRP_A_RECEIVE_FIFO_INFORMATION) wait_for = 8'(`HPRP_CYC_CYCLE);
    if (k == hprp_pkg::rk_tx_sts && t == `HPRP_A_TRANSMIT_FIFO_INFORMATION) wait_for = 8'(`HPRP_CYC_CYCLE);
    if (k == hprp_pkg::rk_drop && t == `HPRP_A_RX_DROP) wait_for = 8'(`HPRP_CYC_LONG);
    if (k == hprp_pkg::rk_dpctl && (t == `HPRP_A_TX_STS || t == `HPRP_A_RX_STS))
      wait_for = 8'(`HPRP_CYC_LONG);
  endfunction : wait_for
  assign need = wait_for(st_ff.last, st_ff.tgt);
  ////////////////////////////////////////////////////////////////////////////
  // sequencer; elapsed time is counted directly, so no dummy reads are needed
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = 16'h0000;
    if (st_ff.since != 8'hff) nxt_st.since = st_ff.since + 8'h01;
    if (reg_read)
      case (reg_addr)
        `HPRP_R_STATUS: nxt_st.rdata = {14'h0000, st_ff.st != hprp_pkg::hs_idle, st_ff.done};
        `HPRP_R_DATA:   nxt_st.rdata = st_ff.data;
        `HPRP_R_COUNT:  nxt_st.rdata = {8'h00, st_ff.since};
        default:        nxt_st.rdata = 16'h0000;
      endcase
    if (reg_read && reg_addr == `HPRP_R_STATUS) nxt_st.done = 1'b0;
    case (st_ff.st)
      hprp_pkg::hs_idle:
        if (reg_write && reg_addr == `HPRP_R_CMD)
        begin
          nxt_st.tgt = reg_wdata[7:0];
          nxt_st.st  = hprp_pkg::hs_gap;
        end
      hprp_pkg::hs_gap:
        if (st_ff.since >= need)
        begin
          nxt_st.a    = st_ff.tgt;
          nxt_st.cs_n = 1'b0;
          nxt_st.rd_n = 1'b0;
          nxt_st.cnt  = 8'h01;
          nxt_st.st   = hprp_pkg::hs_low;
        end
      hprp_pkg::hs_low:
      begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
        // low at least 32 ns and whole cycle at least 165 ns less the high gap
        if (st_ff.cnt >= 8'(`HPRP_CYC_CYCLE - `HPRP_CYC_CSH) && st_ff.cnt >= 8'(`HPRP_CYC_CSL))
        begin
          nxt_st.data = pins.data;
          nxt_st.st   = hprp_pkg::hs_hold;
        end
      end
      hprp_pkg::hs_hold:
      begin
        nxt_st.cs_n  = 1'b1;
        nxt_st.rd_n  = 1'b1;
        nxt_st.since = 8'h00;
        nxt_st.last  = hprp_pkg::hprp_kind(st_ff.a);
        nxt_st.done  = 1'b1;
        nxt_st.st    = hprp_pkg::hs_idle;
      end
      default: nxt_st.st = hprp_pkg::hs_idle;
    endcase
  end
  // state register
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_ff       <= '0;
      st_ff.cs_n  <= 1'b1;
      st_ff.rd_n  <= 1'b1;
      st_ff.since <= 8'hff;
    end
    else if (enable) st_ff <= nxt_st;
  end
endmodule : hprp_host

// file: verilog/hprp_if.sv
// pin-level carrier between host and device read port
// assumes one clock shared by both ends
interface hprp_if;
  logic        chip_select_n;  // active-low select
  logic        read_strobe_n;  // active-low read
  logic [7:0]  addr;           // word address
  logic [15:0] data_out;       // device drive value
  logic        data_oe;        // high while device drives
  wire  [15:0] data = data_oe ? data_out : 16'hffff; // resolved bus, pull-up
  modport device (input chip_select_n, read_strobe_n, addr, output data_out, data_oe);
  modport host   (output chip_select_n, read_strobe_n, addr, input data);
endinterface : hprp_if

// file: verilog/hprp_map.svh
// timing counts and register word addresses for the host read port
// assumes a 100 MHz clock; included by bare name from the package and modules
`ifndef HPRP_MAP_SVH
`define HPRP_MAP_SVH
`define HPRP_CLK_NS        10
`define HPRP_T_CYCLE_NS    165
`define HPRP_T_CSH_NS      13
`define HPRP_T_CSL_NS      32
`define HPRP_T_ADV_NS      40
`define HPRP_T_LONG_NS     330
// least times round up, longest time rounds down
`define HPRP_CYC_CYCLE     ((`HPRP_T_CYCLE_NS + `HPRP_CLK_NS - 1) / `HPRP_CLK_NS)
`define HPRP_CYC_CSH       ((`HPRP_T_CSH_NS + `HPRP_CLK_NS - 1) / `HPRP_CLK_NS)
`define HPRP_CYC_CSL       ((`HPRP_T_CSL_NS + `HPRP_CLK_NS - 1) / `HPRP_CLK_NS)
`define HPRP_CYC_ADV       (`HPRP_T_ADV_NS / `HPRP_CLK_NS)
`define HPRP_CYC_LONG      ((`HPRP_T_LONG_NS + `HPRP_CLK_NS - 1) / `HPRP_CLK_NS)
`define HPRP_BURST_MAX     16
// device word addresses
`define HPRP_A_RX_DATA     8'h00
`define HPRP_A_RX_STS      8'h20
`define HPRP_A_TX_STS      8'h24
`define HPRP_A_BYTE_TEST   8'h32
`define HPRP_A_RECEIVE_DATAPATH_CONTROL  8'h3c
`define HPRP_A_RECEIVE_FIFO_INFORMATION 8'h3e
`define HPRP_A_TRANSMIT_FIFO_INFORMATION 8'h40
`define HPRP_A_RX_DROP     8'h50
`define HPRP_A_FREE_RUN    8'h4e
`define HPRP_BYTE_TEST_VAL 16'h4321
// host-side command register addresses
`define HPRP_R_CMD         4'h0
`define HPRP_R_STATUS      4'h1
`define HPRP_R_DATA        4'h2
`define HPRP_R_COUNT       4'h3
`endif

// file: verilog/hprp_pkg.sv
// types used by the host end of the host read port
// assumes hprp_map.svh is on the include path
`include "hprp_map.svh"
package hprp_pkg;
  // host sequencer states
  typedef enum logic [2:0] {hs_idle, hs_gap, hs_low, hs_hold, hs_wait} hprp_hstate_t;
  // kind of resource last read, for read-after-read waits
  typedef enum logic [2:0] {rk_other, rk_rx_fifo, rk_tx_sts, rk_drop, rk_dpctl} hprp_kind_t;
  // classify a word address
  function automatic hprp_kind_t hprp_kind(input logic [7:0] a);
    // everything below the transmit status word is receive data or receive status
    if (a < `HPRP_A_TX_STS) hprp_kind = rk_rx_fifo;
    else if (a == `HPRP_A_TX_STS) hprp_kind = rk_tx_sts;
    else if (a == `HPRP_A_RX_DROP) hprp_kind = rk_drop;
    else if (a == `HPRP_A_RECEIVE_DATAPATH_CONTROL) hprp_kind = rk_dpctl;
    else hprp_kind = rk_other;
  endfunction : hprp_kind
endpackage : hprp_pkg
